// file: rtl/flash_cfg_pkg.sv
package flash_cfg_pkg;

  // Command opcodes
  localparam logic [7:0] OP_WR_RP_NV = 8'h65;
  localparam logic [7:0] OP_WR_RP_V_A = 8'hC0;
  localparam logic [7:0] OP_WR_RP_V_B = 8'h63;
  localparam logic [7:0] OP_WR_EP_NV = 8'h85;
  localparam logic [7:0] OP_WR_EP_V = 8'h83;
  localparam logic [7:0] OP_RD_RP_NV = 8'h61;
  localparam logic [7:0] OP_RD_EP_NV = 8'h81;
  localparam logic [7:0] OP_LEGACY_ID = 8'hAB;
  localparam logic [7:0] OP_STD_ID = 8'h9F;
  localparam logic [7:0] OP_STD_ID_Q = 8'hAF;

  // Read-parameter field positions
  localparam int WRAP_LEN_LSB = 0;
  localparam int WRAP_EN_BIT = 2;
  localparam int DUMMY_LSB = 3;
  localparam int HOLD_RST_BIT = 7;

  // Reset / factory values
  localparam logic [7:0] RP_NV_INIT = 8'h00;
  localparam logic [7:0] EP_NV_INIT = 8'h60;
  localparam logic [2:0] DRIVE_HALF = 3'h3;
  localparam int DRIVE_LSB = 5;

  // Identity codes, values arbitrary
  localparam logic [7:0] MAKER_CODE = 8'hA5;
  localparam logic [7:0] DEVICE_CODE = 8'h5A;
  localparam logic [15:0] TYPE_CAP_CODE = 16'h1234;

  localparam int LEGACY_DUMMY_BYTES = 3;
  localparam logic [23:0] ADDR_TOP = 24'h1FFFFF;

  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_WR_DATA = 3'b001,
    ST_DUMMY = 3'b010,
    ST_SHIFT_OUT = 3'b011,
    ST_IGNORE = 3'b100
  } cmd_state_t;

  typedef struct packed {
    logic [7:0] read_params;
    logic [7:0] ext_params;
  } param_pair_t;

endpackage : flash_cfg_pkg

// file: rtl/read_config_and_id_commands.sv
// Overview of operation
// R1: 65h writes stored read params; C0h or 63h write live ones; one data byte.
// R2: Read params: wrap field bits 0-2, dummy-cycle field bits 3-6.
// R3: Bit 7 selects reset over hold on shared pin; dedicated pin ignores it.
// R4: Stored read-param write also updates the live copy.
// R5: Bit 2 enables wrap; bits 0-1 pick 8, 16, 32 or 64 bytes.
// R6: Wrap off: address advances by one through whole array.
// R7: Wrap on: start byte first, then increment within aligned boundary, wrapping.
// R8: Wrapped burst runs until chip select rises.
// R9: Byte 00h-03h continuous; 04h-07h give 8, 16, 32, 64 bytes.
// R10: Wrap persists until live write clears it, or reset.
// R11: Wrap enabled means every read uses wrapped addressing.
// R12: 85h writes stored, 83h live extended register; three-bit drive strength.
// R13: Drive strength defaults to half, reducible to one eighth.
// R14: Stored extended write also loads the live extended register.
// R15: 61h returns stored read params, never the live copy.
// R16: 81h returns stored extended params, never the live copy.
// R17: ABh: three dummy bytes in on rising edges, code out MSB first falling.
// R18: Legacy code repeats while chip select low and clocks continue.
// R19: Legacy read works in both single-line and quad command modes.
// R20: 9Fh single, AFh quad: maker code then two-byte code, MSB first.
// R21: Maker and two-byte code loop until chip select rises.
// R22: Maker and device codes 8 bits; type-capacity code 16 bits.
// R23: During suspend, live writes, stored reads and id reads still accepted.
// R24: ABh ignored while a write cycle is in progress.
// R25: Software or hardware reset reloads live registers from stored ones.
// R26: At power-up live registers load from stored ones before first command.
`timescale 1ns/1ps
`default_nettype none
module read_config_and_id_commands
  import flash_cfg_pkg::*;
(
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic [3:0] IO_IN,
  output logic [3:0] IO_OUT,
  output logic [3:0] IO_OE_N,
  input wire logic QUAD_MODE,
  input wire logic WRITE_IN_PROGRESS,
  input wire logic SOFT_RESET,
  input wire logic DEDICATED_RESET_PIN,
  input wire logic [23:0] READ_START_ADDR,
  input wire logic READ_START,
  input wire logic READ_NEXT,
  output logic [23:0] READ_ADDR,
  output logic [3:0] DUMMY_CYCLES,
  output logic HOLD_PIN_IS_RESET,
  output logic [2:0] DRIVE_STRENGTH,
  output param_pair_t LIVE_PARAMS
);

  logic [1:0] cs_s_r, sclk_s_r;
  logic sclk_d_r;
  logic [3:0] io_s1_r, io_s2_r;
  logic cs_n, sclk_rise, sclk_fall, quad;
  logic [7:0] rp_nv_r, rp_v_r, ep_nv_r, ep_v_r;
  cmd_state_t state_r;
  logic [7:0] opcode_r, shin_r;
  logic [3:0] bitcnt_r;
  logic [1:0] dcnt_r;
  logic [23:0] out_sr_r;
  logic [4:0] outlen_r, outpos_r;
  logic [3:0] io_out_r;
  logic drive_r;
  logic boot_r = 1'b0;
  logic [7:0] byte_nxt;
  logic byte_done;
  logic [23:0] addr_r, addr_nxt, wmask;

  // Pin synchronisers
  always_ff @(posedge CLOCK) begin
    cs_s_r <= {cs_s_r[0], CS_N};
    sclk_s_r <= {sclk_s_r[0], SCLK};
    io_s1_r <= IO_IN;
    io_s2_r <= io_s1_r;
    sclk_d_r <= sclk_s_r[1];
  end

  assign cs_n = cs_s_r[1];
  assign sclk_rise = sclk_s_r[1] & ~sclk_d_r;
  assign sclk_fall = ~sclk_s_r[1] & sclk_d_r;
  assign quad = QUAD_MODE;
  // Quad mode takes a nibble per edge, single mode a bit
  assign byte_nxt = quad ? {shin_r[3:0], io_s2_r} : {shin_r[6:0], io_s2_r[0]}; // [R19]
  assign byte_done = quad ? (bitcnt_r == 4'h1) : (bitcnt_r == 4'h7);

  // Stored registers survive reset
  always_ff @(posedge CLOCK) begin
    if (!boot_r) begin
      rp_nv_r <= RP_NV_INIT;
      ep_nv_r <= EP_NV_INIT; // [R13]
    end else if (state_r == ST_WR_DATA && !cs_n && sclk_rise && byte_done
                 && !WRITE_IN_PROGRESS) begin
      if (opcode_r == OP_WR_RP_NV) begin
        rp_nv_r <= byte_nxt; // [R1]
      end
      if (opcode_r == OP_WR_EP_NV) begin
        ep_nv_r <= byte_nxt; // [R12]
      end
    end
  end

  // Power-on flag: every cycle until NRST is first seen high loads the stored values
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      boot_r <= boot_r;
    end else begin
      boot_r <= 1'b1;
    end
  end

  // Live registers
  always_ff @(posedge CLOCK) begin
    if (!NRST || SOFT_RESET || !boot_r) begin
      rp_v_r <= boot_r ? rp_nv_r : RP_NV_INIT; // [R25] [R26]
      ep_v_r <= boot_r ? ep_nv_r : EP_NV_INIT; // [R25] [R26]
    end else if (state_r == ST_WR_DATA && !cs_n && sclk_rise && byte_done) begin
      if (opcode_r == OP_WR_RP_V_A || opcode_r == OP_WR_RP_V_B) begin
        rp_v_r <= byte_nxt; // [R1] [R10] [R23]
      end else if (opcode_r == OP_WR_RP_NV && !WRITE_IN_PROGRESS) begin
        rp_v_r <= byte_nxt; // [R4]
      end
      if (opcode_r == OP_WR_EP_V) begin
        ep_v_r <= byte_nxt; // [R12] [R23]
      end else if (opcode_r == OP_WR_EP_NV && !WRITE_IN_PROGRESS) begin
        ep_v_r <= byte_nxt; // [R14]
      end
    end
  end

  assign LIVE_PARAMS = '{read_params: rp_v_r, ext_params: ep_v_r};
  assign DUMMY_CYCLES = rp_v_r[DUMMY_LSB +: 4]; // [R2]
  assign HOLD_PIN_IS_RESET = rp_v_r[HOLD_RST_BIT] & ~DEDICATED_RESET_PIN; // [R3]
  assign DRIVE_STRENGTH = ep_v_r[DRIVE_LSB +: 3]; // [R12] [R13]

  // Command sequencer
  always_ff @(posedge CLOCK) begin
    if (!NRST || cs_n) begin
      state_r <= ST_OPCODE; // [R8]
      opcode_r <= 8'h00;
      shin_r <= 8'h00;
      bitcnt_r <= 4'h0;
      dcnt_r <= 2'h0;
      out_sr_r <= 24'h000000;
      outlen_r <= 5'h00;
      outpos_r <= 5'h00;
    end else if (sclk_rise && state_r != ST_SHIFT_OUT && state_r != ST_IGNORE) begin
      shin_r <= byte_nxt;
      bitcnt_r <= byte_done ? 4'h0 : bitcnt_r + 4'h1;
      if (byte_done) begin
        unique case (state_r)
          ST_OPCODE: begin
            opcode_r <= byte_nxt;
            outpos_r <= 5'h00;
            if (byte_nxt == OP_WR_RP_NV || byte_nxt == OP_WR_RP_V_A ||
                byte_nxt == OP_WR_RP_V_B || byte_nxt == OP_WR_EP_NV ||
                byte_nxt == OP_WR_EP_V) begin
              state_r <= ST_WR_DATA;
            end else if (byte_nxt == OP_RD_RP_NV) begin
              out_sr_r <= {rp_nv_r, 16'h0000}; // [R15]
              outlen_r <= 5'd8;
              state_r <= ST_SHIFT_OUT;
            end else if (byte_nxt == OP_RD_EP_NV) begin
              out_sr_r <= {ep_nv_r, 16'h0000}; // [R16]
              outlen_r <= 5'd8;
              state_r <= ST_SHIFT_OUT;
            end else if (byte_nxt == OP_LEGACY_ID) begin
              state_r <= WRITE_IN_PROGRESS ? ST_IGNORE : ST_DUMMY; // [R24]
            end else if ((byte_nxt == OP_STD_ID && !quad) ||
                         (byte_nxt == OP_STD_ID_Q && quad)) begin
              out_sr_r <= {MAKER_CODE, TYPE_CAP_CODE}; // [R20] [R22]
              outlen_r <= 5'd24;
              state_r <= ST_SHIFT_OUT;
            end else begin
              state_r <= ST_IGNORE;
            end
          end
          ST_WR_DATA: state_r <= ST_IGNORE;
          ST_DUMMY: begin
            dcnt_r <= dcnt_r + 2'h1;
            if (dcnt_r == 2'(LEGACY_DUMMY_BYTES - 1)) begin
              out_sr_r <= {DEVICE_CODE, 16'h0000}; // [R17] [R22]
              outlen_r <= 5'd8;
              state_r <= ST_SHIFT_OUT;
            end
          end
          default: state_r <= ST_IGNORE;
        endcase
      end
    end else if (sclk_fall && state_r == ST_SHIFT_OUT) begin
      // Pointer wraps to repeat the code
      if (quad) begin
        outpos_r <= (outpos_r + 5'd4 >= outlen_r) ? 5'h00 : outpos_r + 5'd4; // [R18] [R21]
      end else begin
        outpos_r <= (outpos_r + 5'd1 >= outlen_r) ? 5'h00 : outpos_r + 5'd1; // [R18] [R21]
      end
    end
  end

  // Output drive, MSB first on falling edges
  always_ff @(posedge CLOCK) begin
    if (!NRST || cs_n) begin
      io_out_r <= 4'h0;
      drive_r <= 1'b0;
    end else if (sclk_fall && state_r == ST_SHIFT_OUT) begin
      drive_r <= 1'b1;
      if (quad) begin
        io_out_r <= out_sr_r[5'd23 - outpos_r -: 4]; // [R17] [R20]
      end else begin
        io_out_r <= {2'b00, out_sr_r[5'd23 - outpos_r], 1'b0}; // [R17] [R20]
      end
    end
  end

  assign IO_OUT = io_out_r;
  assign IO_OE_N = !drive_r ? 4'hF : (quad ? 4'h0 : 4'hD);

  // Read address sequencer
  always_comb begin
    unique case (rp_v_r[WRAP_LEN_LSB +: 2]) // [R5] [R9]
      2'b00: wmask = 24'h000007;
      2'b01: wmask = 24'h00000F;
      2'b10: wmask = 24'h00001F;
      default: wmask = 24'h00003F;
    endcase
    if (rp_v_r[WRAP_EN_BIT]) begin
      addr_nxt = (addr_r & ~wmask) | ((addr_r + 24'h000001) & wmask); // [R7] [R11]
    end else begin
      addr_nxt = (addr_r == ADDR_TOP) ? 24'h000000 : addr_r + 24'h000001; // [R6]
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      addr_r <= 24'h000000;
    end else if (READ_START) begin
      addr_r <= READ_START_ADDR; // [R7]
    end else if (READ_NEXT) begin
      addr_r <= addr_nxt; // [R8]
    end
  end

  assign READ_ADDR = addr_r;

  // Wrap stays inside the aligned boundary
  property p_wrap_in_block;
    @(posedge CLOCK) disable iff (!NRST)
      (READ_NEXT && !READ_START && rp_v_r[WRAP_EN_BIT]) |=>
        ((READ_ADDR & ~wmask) == ($past(READ_ADDR) & ~$past(wmask)));
  endproperty
  a_wrap_in_block: assert property (p_wrap_in_block) // [R7]
    else $error("wrapped address left its boundary");

  property p_linear_step;
    @(posedge CLOCK) disable iff (!NRST)
      (READ_NEXT && !READ_START && !rp_v_r[WRAP_EN_BIT] && READ_ADDR != ADDR_TOP) |=>
        (READ_ADDR == $past(READ_ADDR) + 24'h000001);
  endproperty
  a_linear_step: assert property (p_linear_step) // [R6]
    else $error("linear address did not step by one");

  property p_nv_copies_live;
    @(posedge CLOCK) disable iff (!NRST)
      $changed(rp_nv_r) && boot_r && $past(boot_r) |-> rp_v_r == rp_nv_r;
  endproperty
  a_nv_copies_live: assert property (p_nv_copies_live) // [R4]
    else $error("live read params not updated with stored");

  property p_ext_nv_copies;
    @(posedge CLOCK) disable iff (!NRST)
      $changed(ep_nv_r) && boot_r && $past(boot_r) |-> ep_v_r == ep_nv_r;
  endproperty
  a_ext_nv_copies: assert property (p_ext_nv_copies) // [R14]
    else $error("live ext params not updated with stored");

  property p_reset_reload;
    @(posedge CLOCK) (boot_r && (!NRST || SOFT_RESET)) |=>
      (rp_v_r == $past(rp_nv_r) && ep_v_r == $past(ep_nv_r));
  endproperty
  a_reset_reload: assert property (p_reset_reload) // [R25]
    else $error("reset did not reload live registers");

  property p_legacy_ignored_busy;
    @(posedge CLOCK) disable iff (!NRST)
      (state_r == ST_OPCODE && !cs_n && sclk_rise && byte_done &&
       byte_nxt == OP_LEGACY_ID && WRITE_IN_PROGRESS) |=> state_r == ST_IGNORE;
  endproperty
  a_legacy_ignored_busy: assert property (p_legacy_ignored_busy) // [R24]
    else $error("legacy id accepted while busy");

  property p_hold_select;
    @(posedge CLOCK) disable iff (!NRST)
      DEDICATED_RESET_PIN |-> !HOLD_PIN_IS_RESET;
  endproperty
  a_hold_select: assert property (p_hold_select) // [R3]
    else $error("dedicated reset pin honoured select bit");

  property p_no_drive_idle;
    @(posedge CLOCK) disable iff (!NRST)
      cs_n |=> IO_OE_N == 4'hF;
  endproperty
  a_no_drive_idle: assert property (p_no_drive_idle) // [R8]
    else $error("output driven with chip select high");

  property p_outpos_bound;
    @(posedge CLOCK) disable iff (!NRST)
      state_r == ST_SHIFT_OUT |-> outpos_r < outlen_r;
  endproperty
  a_outpos_bound: assert property (p_outpos_bound) // [R21]
    else $error("output pointer beyond code length");

  property p_start_loads;
    @(posedge CLOCK) disable iff (!NRST)
      READ_START |=> READ_ADDR == $past(READ_START_ADDR);
  endproperty
  a_start_loads: assert property (p_start_loads) // [R7]
    else $error("read address not loaded from start");

  property p_wrap_returns;
    @(posedge CLOCK) disable iff (!NRST)
      (READ_NEXT && !READ_START && rp_v_r[WRAP_EN_BIT] &&
       (READ_ADDR & wmask) == wmask) |=>
        ((READ_ADDR & $past(wmask)) == 24'h000000);
  endproperty
  a_wrap_returns: assert property (p_wrap_returns) // [R7]
    else $error("wrapped address did not return to boundary start");

  property p_legacy_dummies;
    @(posedge CLOCK) disable iff (!NRST)
      (state_r == ST_DUMMY && !cs_n && sclk_rise && byte_done &&
       dcnt_r == 2'(LEGACY_DUMMY_BYTES - 1)) |=> state_r == ST_SHIFT_OUT;
  endproperty
  a_legacy_dummies: assert property (p_legacy_dummies) // [R17]
    else $error("legacy code not started after dummy bytes");

  property p_live_write;
    @(posedge CLOCK) disable iff (!NRST)
      (state_r == ST_WR_DATA && !cs_n && sclk_rise && byte_done && boot_r &&
       !SOFT_RESET && opcode_r == OP_WR_EP_V) |=> ep_v_r == $past(byte_nxt);
  endproperty
  a_live_write: assert property (p_live_write) // [R12]
    else $error("live ext params not written");

endmodule : read_config_and_id_commands
`default_nettype wire

// file: verification/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic CLOCK,
  input wire logic QUAD_MODE,
  input wire logic [3:0] IO_OUT,
  input wire logic [3:0] IO_OE_N,
  output logic CS_N,
  output logic SCLK,
  output logic [3:0] IO_IN
);
  logic [3:0] seen_r;
  initial begin
    CS_N = 1'b1;
    SCLK = 1'b0;
    IO_IN = 4'h0;
    seen_r = 4'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : tick
  // One byte, MSB first; a released line reads as its inverse
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    int bits;
    logic [3:0] ln;
    bits = QUAD_MODE ? 2 : 8;
    rx = 8'h00;
    for (int i = 0; i < bits; i++) begin
      IO_IN = QUAD_MODE ? tx[7-4*i -: 4] : {3'h0, tx[7-i]};
      tick(4);
      SCLK = 1'b1;
      tick(3);
      for (int j = 0; j < 4; j++) ln[j] = IO_OE_N[j] ? ~seen_r[j] : IO_OUT[j];
      seen_r = ln;
      rx = QUAD_MODE ? {rx[3:0], ln} : {rx[6:0], ln[1]};
      tick(1);
      SCLK = 1'b0;
    end
  endtask : xbyte
  // Frame: tx_n bytes out, rx_n bytes in, then chip select rises
  task automatic frame(input logic [31:0] tx, input int tx_n, input int rx_n,
                       output logic [31:0] rx);
    logic [7:0] b;
    rx = 32'h0;
    CS_N = 1'b0;
    tick(4);
    for (int k = 0; k < tx_n; k++) xbyte(tx[31-8*k -: 8], b);
    for (int k = 0; k < rx_n; k++) begin
      xbyte(8'hFF, b);
      rx = {rx[23:0], b};
    end
    tick(4);
    CS_N = 1'b1;
    IO_IN = ~IO_IN;
    tick(8);
  endtask : frame
endmodule : host_model
`default_nettype wire

// file: verification/read_config_and_id_commands_test.sv
`timescale 1ns/1ps
`default_nettype none
module read_config_and_id_commands_test
  import flash_cfg_pkg::*;
;
  logic clock, nrst, cs_n, sclk, quad_mode, write_in_progress, soft_reset;
  logic dedicated_reset_pin, read_start, read_next, hold_pin_is_reset, driven;
  logic [3:0] io_in, io_out, io_oe_n, dummy_cycles;
  logic [23:0] read_start_addr, read_addr;
  logic [2:0] drive_strength;
  logic [31:0] rx;
  param_pair_t live_params;
  int miscompares = 0;
  int cmp_count = 0;
  read_config_and_id_commands u_read_config_and_id_commands (.CLOCK(clock), .NRST(nrst),
    .CS_N(cs_n), .SCLK(sclk), .IO_IN(io_in), .IO_OUT(io_out), .IO_OE_N(io_oe_n),
    .QUAD_MODE(quad_mode), .WRITE_IN_PROGRESS(write_in_progress), .SOFT_RESET(soft_reset),
    .DEDICATED_RESET_PIN(dedicated_reset_pin), .READ_START_ADDR(read_start_addr),
    .READ_START(read_start), .READ_NEXT(read_next), .READ_ADDR(read_addr),
    .DUMMY_CYCLES(dummy_cycles), .HOLD_PIN_IS_RESET(hold_pin_is_reset),
    .DRIVE_STRENGTH(drive_strength), .LIVE_PARAMS(live_params));
  host_model u_host_model (.CLOCK(clock), .QUAD_MODE(quad_mode), .IO_OUT(io_out),
    .IO_OE_N(io_oe_n), .CS_N(cs_n), .SCLK(sclk), .IO_IN(io_in));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) if (io_oe_n !== 4'hF) driven = 1'b1;
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int n, input int rn);
    u_host_model.frame({op, d, 16'h0}, n, rn, rx);
  endtask : cmd
  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic t_reset;
    chk("live", {16'h0, RP_NV_INIT, EP_NV_INIT}, live_params);
    chk("drive", DRIVE_HALF, drive_strength);
    chk("oe", 4'hF, io_oe_n);
  endtask : t_reset
  task automatic t_params;
    cmd(OP_WR_RP_V_A, 8'hFB, 2, 0);
    chk("rp", 8'hFB, live_params.read_params);
    chk("dummy", 4'hF, dummy_cycles);
    chk("hold", 1'b1, hold_pin_is_reset);
    dedicated_reset_pin = 1'b1;
    tick(2);
    chk("hold", 1'b0, hold_pin_is_reset);
    dedicated_reset_pin = 1'b0;
    cmd(OP_RD_RP_NV, 8'h0, 1, 2);
    chk("rd61", {2{RP_NV_INIT}}, rx[15:0]);
    cmd(OP_WR_RP_V_B, 8'h1A, 2, 0);
    chk("dummy", 4'h3, dummy_cycles);
    cmd(OP_WR_RP_NV, 8'h2D, 2, 0);
    chk("rp", 8'h2D, live_params.read_params);
    cmd(OP_RD_RP_NV, 8'h0, 1, 2);
    chk("rd61", 16'h2D2D, rx[15:0]);
    cmd(OP_WR_EP_V, 8'hE0, 2, 0);
    chk("drive", 3'h7, drive_strength);
    cmd(OP_RD_EP_NV, 8'h0, 1, 1);
    chk("rd81", EP_NV_INIT, rx[7:0]);
    cmd(OP_WR_EP_NV, 8'h20, 2, 0);
    chk("ep", 8'h20, live_params.ext_params);
    cmd(OP_RD_EP_NV, 8'h0, 1, 1);
    chk("rd81", 8'h20, rx[7:0]);
  endtask : t_params
  task automatic t_ids;
    for (int q = 0; q < 2; q++) begin
      quad_mode = q[0];
      cmd(OP_WR_RP_V_A, 8'h78 - 8'(8 * q), 2, 0);
      chk("dummy", 4'hF - 4'(q), dummy_cycles);
      cmd(OP_RD_RP_NV, 8'h0, 1, 1);
      chk("rd61", 8'h2D, rx[7:0]);
      cmd(OP_LEGACY_ID, 8'h0, 4, 2);
      chk("legacy", {2{DEVICE_CODE}}, rx[15:0]);
      cmd(q ? OP_STD_ID_Q : OP_STD_ID, 8'h0, 1, 4);
      chk("std", {MAKER_CODE, TYPE_CAP_CODE, MAKER_CODE}, rx);
    end
    quad_mode = 1'b0;
  endtask : t_ids
  task automatic t_busy;
    write_in_progress = 1'b1;
    driven = 1'b0;
    cmd(OP_LEGACY_ID, 8'h0, 4, 1);
    chk("driven", 1'b0, driven);
    cmd(OP_WR_EP_V, 8'h60, 2, 0);
    chk("drive", DRIVE_HALF, drive_strength);
    cmd(OP_RD_EP_NV, 8'h0, 1, 1);
    chk("rd81", 8'h20, rx[7:0]);
    write_in_progress = 1'b0;
  endtask : t_busy
  task automatic seq(input logic [23:0] s, input logic [23:0] e1, input logic [23:0] e2);
    read_start_addr = s;
    read_start = 1'b1;
    tick(1);
    read_start = 1'b0;
    tick(2);
    chk("addr", s, read_addr);
    for (int i = 0; i < 2; i++) begin
      read_next = 1'b1;
      tick(1);
      read_next = 1'b0;
      tick(2);
      chk("addr", i ? e2 : e1, read_addr);
    end
  endtask : seq
  task automatic t_wrap;
    for (int k = 0; k < 4; k++) begin
      cmd(OP_WR_RP_V_A, 8'h04 + 8'(k), 2, 0);
      seq(24'h0123FE, 24'h0123FF, 24'h0123FE & ~((24'h8 << k) - 24'h1));
    end
    cmd(OP_WR_RP_V_B, 8'h03, 2, 0);
    seq(24'h0123FE, 24'h0123FF, 24'h012400);
  endtask : t_wrap
  task automatic t_resets;
    soft_reset = 1'b1;
    tick(2);
    soft_reset = 1'b0;
    tick(4);
    chk("live", 16'h2D20, live_params);
    cmd(OP_WR_EP_V, 8'hE0, 2, 0);
    nrst = 1'b0;
    tick(3);
    nrst = 1'b1;
    tick(8);
    chk("live", 16'h2D20, live_params);
  endtask : t_resets
  initial begin
    repeat (100000) @(posedge clock);
    miscompares++;
    end_sim();
  end
  initial begin
    {nrst, quad_mode, write_in_progress, soft_reset} = 4'h0;
    {dedicated_reset_pin, read_start, read_next, driven} = 4'h0;
    read_start_addr = 24'h0;
    tick(6);
    nrst = 1'b1;
    tick(8);
    t_reset();
    t_params();
    t_ids();
    t_busy();
    t_wrap();
    t_resets();
    end_sim();
  end
endmodule : read_config_and_id_commands_test
`default_nettype wire
